// >>> bench/test_user_break_control.sv
// Self-checking bench joining both ends of the user break control block.
`timescale 1ns/1ps
module test_user_break_control;
    typedef struct {logic [31:0] ctl; ubc_pkg::ubc_cycle_t cyc; logic [1:0] brk; logic [31:0] rb;} ubc_row_t;
    logic                core_clk = 1'h0;
    logic                reset_n = 1'h0;
    ubc_pkg::ubc_cycle_t usr_cycle = '0;
    logic                usr_wr = 1'h0, usr_rd = 1'h0;
    logic [1:0]          usr_addr = 2'h0;
    logic [31:0]         usr_wdata = 32'h0;
    logic [31:0]         usr_rdata;
    logic                usr_break, usr_break_after, usr_pc_trace;
    int                  bad_count = 0, num_checks = 0, cycles = 0;
    ubc_row_t            rows[13];
    ubc_if lnk_bus();
    ubc_core_end ubc_core_end_inst (.core_clk(core_clk), .reset_n(reset_n), .lnk(lnk_bus), .usr_cycle(usr_cycle),
        .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_rdata(usr_rdata),
        .usr_break(usr_break), .usr_break_after(usr_break_after), .usr_pc_trace(usr_pc_trace));
    ubc_dev_end ubc_dev_end_inst (.core_clk(core_clk), .reset_n(reset_n), .lnk(lnk_bus));
    ubc_properties ubc_properties_inst (.core_clk(core_clk), .reset_n(reset_n), .cycle(lnk_bus.cycle),
        .reg_wr(lnk_bus.reg_wr), .reg_rd(lnk_bus.reg_rd), .reg_addr(lnk_bus.reg_addr), .reg_wdata(lnk_bus.reg_wdata),
        .reg_rdata(lnk_bus.reg_rdata), .brk_req(lnk_bus.brk_req), .brk_after(lnk_bus.brk_after),
        .pc_trace_on(lnk_bus.pc_trace_on));
    always #25 core_clk = ~core_clk;
    // Code k holds dma, fetch, hit A, hit B and data hit, high bit first.
    function automatic ubc_pkg::ubc_cycle_t cy(input logic [4:0] k, input logic [7:0] asid = 8'h5A);
        return {1'h1, k[4:3], asid, k[2:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        usr_addr = a;
        usr_wdata = d;
        usr_wr = 1'h1;
        @(negedge core_clk);
        usr_wr = 1'h0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [31:0] e);
        usr_addr = a;
        usr_rd = 1'h1;
        @(negedge core_clk);
        usr_rd = 1'h0;
        repeat (2) @(negedge core_clk);
        chk(usr_rdata, e);
    endtask
    task automatic hit(input ubc_pkg::ubc_cycle_t c, input logic [1:0] e);
        usr_cycle = c;
        @(negedge core_clk);
        usr_cycle = '0;
        repeat (2) @(negedge core_clk);
        chk({30'h0, usr_break, usr_break_after}, {30'h0, e});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            bad_count++;
            report_and_stop;
        end
    end
    initial begin
        rows[0] = '{32'h0, cy(5'h0C), 2'h2, 32'h8000};
        rows[1] = '{32'h400, cy(5'h0C), 2'h3, 32'h8400};
        rows[2] = '{32'h40, cy(5'h0B), 2'h3, 32'h4040};
        rows[3] = '{32'h0, cy(5'h14), 2'h2, 32'h2000};
        rows[4] = '{32'h0, cy(5'h12), 2'h2, 32'h1000};
        rows[5] = '{32'h80, cy(5'h02), 2'h0, 32'h80};
        rows[6] = '{32'h80, cy(5'h03), 2'h2, 32'h4080};
        rows[7] = '{32'h0, cy(5'h04, 8'h00), 2'h0, 32'h0};
        rows[8] = '{32'h200000, cy(5'h04, 8'h00), 2'h2, 32'h208000};
        rows[9] = '{32'h0, cy(5'h02, 8'h00), 2'h0, 32'h0};
        rows[10] = '{32'h100000, cy(5'h02, 8'h00), 2'h2, 32'h104000};
        rows[11] = '{32'h8, cy(5'h04), 2'h0, 32'h8008};
        rows[12] = '{32'hFFFFFFFF, '0, 2'h0, 32'h00300CC9};
        repeat (4) @(negedge core_clk);
        reset_n = 1'h1;
        rd(2'h0, 32'h0);
        rd(2'h1, 32'h0);
        chk({31'h0, usr_pc_trace}, 32'h0);
        wr(2'h2, 32'h5A);
        wr(2'h3, 32'h5A);
        rd(2'h2, 32'h5A);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(2'h0, rows[i].ctl);
            hit(rows[i].cyc, rows[i].brk);
            rd(2'h0, rows[i].rb);
            wr(2'h0, 32'h0);
        end
        $display("test table done");
        wr(2'h0, 32'h800);
        rd(2'h0, 32'h800);
        chk({31'h0, usr_pc_trace}, 32'h1);
        hit(cy(5'h04), 2'h2);
        wr(2'h0, 32'hF800);
        rd(2'h0, 32'h8800);
        wr(2'h0, 32'h0);
        rd(2'h0, 32'h0);
        $display("test flags done");
        wr(2'h0, 32'h8);
        hit(cy(5'h04), 2'h0);
        hit(cy(5'h03), 2'h2);
        hit(cy(5'h03), 2'h0);
        $display("test sequence done");
        wr(2'h0, 32'h1);
        wr(2'h1, 32'h3);
        hit(cy(5'h03), 2'h0);
        hit(cy(5'h03), 2'h0);
        rd(2'h1, 32'h1);
        hit(cy(5'h03), 2'h2);
        wr(2'h1, 32'hFFFFFFFF);
        rd(2'h1, 32'hFFF);
        wr(2'h0, 32'h0);
        hit(cy(5'h03), 2'h2);
        $display("test count done");
        report_and_stop;
    end
endmodule

// >>> bench/ubc_properties.sv
// Concurrent checks on the link between the two ends of the user break control block.
`timescale 1ns/1ps
`include "ubc_cfg.svh"
module ubc_properties (
    input wire logic                core_clk,
    input wire logic                reset_n,
    input wire ubc_pkg::ubc_cycle_t cycle,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [1:0]          reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic [31:0]         reg_rdata,
    input wire logic                brk_req,
    input wire logic                brk_after,
    input wire logic                pc_trace_on
);
    // ********************************************
    // Shadow of the writable control bits, flags left out.
    // ********************************************
    logic [31:0] ctl_r;
    logic [31:0] ctl_nxt;
    wire         ctl_wr = reg_wr && reg_addr == `UBC_ADDR_CTRL;
    wire         a_only = cycle.valid && cycle.addr_a_hit && !cycle.addr_b_hit;
    wire         b_only = cycle.valid && cycle.addr_b_hit && !cycle.addr_a_hit;
    always_comb begin
        ctl_nxt = ctl_wr ? (reg_wdata & `UBC_CTRL_WMASK & ~`UBC_CTRL_FLAGS) : ctl_r;
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_r <= `UBC_CTRL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ********************************************
    // Assertions and covers.
    // ********************************************
    reset_clear_a: assert property ($rose(reset_n) |-> !pc_trace_on && !brk_req)
        else $error("trace or break active right after reset");
    rsvd_zero_a: assert property (reg_rd && reg_addr == `UBC_ADDR_CTRL |=> (reg_rdata & ~`UBC_CTRL_WMASK) == 32'h0)
        else $error("reserved control bits read nonzero");
    count_width_a: assert property (reg_rd && reg_addr == `UBC_ADDR_EXEC_COUNT |=> reg_rdata[31:12] == 20'h0)
        else $error("count read wider than twelve bits");
    asid_width_a: assert property (reg_rd && reg_addr[1] |=> reg_rdata[31:8] == 24'h0)
        else $error("asid read wider than eight bits");
    trace_follow_a: assert property (ctl_wr |=> pc_trace_on == $past(reg_wdata[11]))
        else $error("trace enable does not follow write");
    break_cause_a: assert property (brk_req |-> $past(cycle.valid && (cycle.addr_a_hit || cycle.addr_b_hit)))
        else $error("break without a channel hit");
    after_chan_a: assert property (brk_req && $past(a_only && cycle.is_fetch) |-> brk_after == $past(ctl_r[10]))
        else $error("channel A break timing wrong");
    after_b_time_a: assert property (brk_req && $past(b_only && cycle.is_fetch) |-> brk_after == $past(ctl_r[6]))
        else $error("channel B break timing wrong");
    seq_a_alone_a: assert property (a_only && ctl_r[3] |=> !brk_req)
        else $error("sequential mode broke on channel A alone");
    mask_a_fire_a: assert property (a_only && ctl_r[21] && !ctl_r[3] |=> brk_req)
        else $error("unmasked channel A hit gave no break");
    data_b_block_a: assert property (b_only && ctl_r[7] && !cycle.data_b_hit |=> !brk_req)
        else $error("channel B broke without data match");
    mask_b_fire_a: assert property (b_only && ctl_r[20] && ctl_r[3:0] == 4'h0 && (cycle.data_b_hit || !ctl_r[7])
        |=> brk_req)
        else $error("unmasked channel B hit gave no break");
    cover property (brk_req && brk_after);
    cover property (a_only && ctl_r[3]);
    cover property (reg_rd && reg_addr == `UBC_ADDR_EXEC_COUNT);
endmodule

// >>> logic/ubc_cfg.svh
// Offsets, bit positions, reset values and field widths of the user break control block.
`ifndef UBC_CFG_SVH
`define UBC_CFG_SVH
`define UBC_ADDR_CTRL       2'h0
`define UBC_ADDR_EXEC_COUNT 2'h1
`define UBC_ADDR_ASID_A     2'h2
`define UBC_ADDR_ASID_B     2'h3
`define UBC_BIT_ASID_MASK_A 21
`define UBC_BIT_ASID_MASK_B 20
`define UBC_BIT_CPU_FLAG_A  15
`define UBC_BIT_CPU_FLAG_B  14
`define UBC_BIT_DMA_FLAG_A  13
`define UBC_BIT_DMA_FLAG_B  12
`define UBC_BIT_PC_TRACE    11
`define UBC_BIT_AFTER_A     10
`define UBC_BIT_DATA_B      7
`define UBC_BIT_AFTER_B     6
`define UBC_BIT_SEQ         3
`define UBC_BIT_EXEC_EN     0
`define UBC_CTRL_WMASK      32'h0030FCC9
`define UBC_CTRL_FLAGS      32'h0000F000
`define UBC_CTRL_RESET      32'h00000000
`define UBC_COUNT_W         12
`define UBC_COUNT_RESET     12'h000
`define UBC_COUNT_ONE       12'h001
`endif

// >>> logic/ubc_core_end.sv
// Core-side end: drives watched bus cycles and register accesses onto the link.
`timescale 1ns/1ps
`include "ubc_cfg.svh"
module ubc_core_end (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    ubc_if.core                      lnk,
    input  wire ubc_pkg::ubc_cycle_t usr_cycle,
    input  wire logic                usr_wr,
    input  wire logic                usr_rd,
    input  wire logic [1:0]          usr_addr,
    input  wire logic [31:0]         usr_wdata,
    output logic [31:0]              usr_rdata,
    output logic                     usr_break,
    output logic                     usr_break_after,
    output logic                     usr_pc_trace
);
    ubc_pkg::ubc_cycle_t cyc_r;
    ubc_pkg::ubc_cycle_t cyc_nxt;
    logic        wr_r, wr_nxt, rd_r, rd_nxt;
    logic [1:0]  addr_r, addr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic        brk_r, brk_nxt, after_r, after_nxt, trace_r, trace_nxt;

    // ****************************************
    // Link registers
    // ****************************************
    always_comb begin
        cyc_nxt   = usr_cycle;
        wr_nxt    = usr_wr;
        rd_nxt    = usr_rd;
        addr_nxt  = usr_addr;
        // Reserved control bits are cleared here before the write reaches the link.
        wdata_nxt = (usr_addr == `UBC_ADDR_CTRL) ? (usr_wdata & `UBC_CTRL_WMASK) : usr_wdata;
        rdata_nxt = lnk.reg_rdata;
        brk_nxt   = lnk.brk_req;
        after_nxt = lnk.brk_after;
        trace_nxt = lnk.pc_trace_on;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_r   <= '0;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            addr_r  <= 2'h0;
            wdata_r <= 32'h00000000;
            rdata_r <= 32'h00000000;
            brk_r   <= 1'b0;
            after_r <= 1'b0;
            trace_r <= 1'b0;
        end else begin
            cyc_r   <= cyc_nxt;
            wr_r    <= wr_nxt;
            rd_r    <= rd_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            brk_r   <= brk_nxt;
            after_r <= after_nxt;
            trace_r <= trace_nxt;
        end
    end

    assign lnk.cycle     = cyc_r;
    assign lnk.reg_wr    = wr_r;
    assign lnk.reg_rd    = rd_r;
    assign lnk.reg_addr  = addr_r;
    assign lnk.reg_wdata = wdata_r;
    assign usr_rdata       = rdata_r;
    assign usr_break       = brk_r;
    assign usr_break_after = after_r;
    assign usr_pc_trace    = trace_r;
endmodule

// >>> logic/ubc_dev_end.sv
// Device end: break control register, match flags, sequence and execution-count logic.
`timescale 1ns/1ps
`include "ubc_cfg.svh"
module ubc_dev_end (
    input  wire logic core_clk,
    input  wire logic reset_n,
    ubc_if.dev        lnk
);
    logic [31:0]              ctrl_r, ctrl_nxt;
    logic [`UBC_COUNT_W-1:0]  count_r, count_nxt;
    logic [7:0]               asid_a_r, asid_a_nxt, asid_b_r, asid_b_nxt;
    ubc_pkg::ubc_seq_t        seq_r, seq_nxt;
    logic [31:0]              rdata_r, rdata_nxt;
    logic                     brk_r, brk_nxt, after_r, after_nxt;
    logic                     hit_a, hit_b, fire_b, wr_ctrl;

    // Channel match including optional ASID compare.
    function automatic logic chan_hit(input logic addr_hit, input logic mask, input logic [7:0] want,
                                      input logic [7:0] got);
        chan_hit = addr_hit && (mask || (want == got));
    endfunction

    // ****************************************
    // Match and break decision
    // ****************************************
    always_comb begin
        wr_ctrl   = lnk.reg_wr && (lnk.reg_addr == `UBC_ADDR_CTRL);
        hit_a     = lnk.cycle.valid && chan_hit(lnk.cycle.addr_a_hit, ctrl_r[`UBC_BIT_ASID_MASK_A],
                                                asid_a_r, lnk.cycle.asid);
        hit_b     = lnk.cycle.valid && chan_hit(lnk.cycle.addr_b_hit, ctrl_r[`UBC_BIT_ASID_MASK_B],
                                                asid_b_r, lnk.cycle.asid)
                    && (!ctrl_r[`UBC_BIT_DATA_B] || lnk.cycle.data_b_hit);
        seq_nxt   = seq_r;
        count_nxt = count_r;
        fire_b    = hit_b;
        if (ctrl_r[`UBC_BIT_SEQ]) begin
            fire_b = hit_b && (seq_r == ubc_pkg::UBC_SEQ_ARMED);
            case (seq_r)
                ubc_pkg::UBC_SEQ_IDLE:  seq_nxt = hit_a ? ubc_pkg::UBC_SEQ_ARMED : ubc_pkg::UBC_SEQ_IDLE;
                ubc_pkg::UBC_SEQ_ARMED: seq_nxt = hit_b ? ubc_pkg::UBC_SEQ_IDLE : ubc_pkg::UBC_SEQ_ARMED;
                default:                seq_nxt = ubc_pkg::UBC_SEQ_IDLE;
            endcase
        end else begin
            seq_nxt = ubc_pkg::UBC_SEQ_IDLE;
        end
        if (ctrl_r[`UBC_BIT_EXEC_EN] && fire_b) begin
            if (count_r > `UBC_COUNT_ONE) begin
                count_nxt = count_r - `UBC_COUNT_ONE;
                fire_b    = 1'b0;
            end
        end
        if (lnk.reg_wr && (lnk.reg_addr == `UBC_ADDR_EXEC_COUNT)) begin
            count_nxt = lnk.reg_wdata[`UBC_COUNT_W-1:0];
        end
        brk_nxt   = (hit_a && !ctrl_r[`UBC_BIT_SEQ]) || fire_b;
        // On fetch cycles timing follows channel B when it fires, otherwise channel A; other cycles give zero.
        after_nxt = lnk.cycle.is_fetch && (fire_b ? ctrl_r[`UBC_BIT_AFTER_B] : ctrl_r[`UBC_BIT_AFTER_A]);
    end

    // ****************************************
    // Control register and other registers
    // ****************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            // Writable bits follow the write; flags only accept zero.
            ctrl_nxt = (lnk.reg_wdata & `UBC_CTRL_WMASK & ~`UBC_CTRL_FLAGS)
                     | (ctrl_r & lnk.reg_wdata & `UBC_CTRL_FLAGS);
        end
        // Sets come last so a match beats a clearing write.
        if (hit_a && !lnk.cycle.is_dma) ctrl_nxt[`UBC_BIT_CPU_FLAG_A] = 1'b1;
        if (hit_b && !lnk.cycle.is_dma) ctrl_nxt[`UBC_BIT_CPU_FLAG_B] = 1'b1;
        if (hit_a && lnk.cycle.is_dma)  ctrl_nxt[`UBC_BIT_DMA_FLAG_A] = 1'b1;
        if (hit_b && lnk.cycle.is_dma)  ctrl_nxt[`UBC_BIT_DMA_FLAG_B] = 1'b1;
        asid_a_nxt = (lnk.reg_wr && lnk.reg_addr == `UBC_ADDR_ASID_A) ? lnk.reg_wdata[7:0] : asid_a_r;
        asid_b_nxt = (lnk.reg_wr && lnk.reg_addr == `UBC_ADDR_ASID_B) ? lnk.reg_wdata[7:0] : asid_b_r;
        case (lnk.reg_addr)
            `UBC_ADDR_CTRL:       rdata_nxt = ctrl_r & `UBC_CTRL_WMASK;
            `UBC_ADDR_EXEC_COUNT: rdata_nxt = {20'h00000, count_r};
            `UBC_ADDR_ASID_A:     rdata_nxt = {24'h000000, asid_a_r};
            `UBC_ADDR_ASID_B:     rdata_nxt = {24'h000000, asid_b_r};
            default:              rdata_nxt = 32'h00000000;
        endcase
        if (!lnk.reg_rd) rdata_nxt = rdata_r;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r   <= `UBC_CTRL_RESET;
            count_r  <= `UBC_COUNT_RESET;
            asid_a_r <= 8'h00;
            asid_b_r <= 8'h00;
            seq_r    <= ubc_pkg::UBC_SEQ_IDLE;
            rdata_r  <= 32'h00000000;
            brk_r    <= 1'b0;
            after_r  <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            count_r  <= count_nxt;
            asid_a_r <= asid_a_nxt;
            asid_b_r <= asid_b_nxt;
            seq_r    <= seq_nxt;
            rdata_r  <= rdata_nxt;
            brk_r    <= brk_nxt;
            after_r  <= after_nxt;
        end
    end

    assign lnk.reg_rdata   = rdata_r;
    assign lnk.brk_req     = brk_r;
    assign lnk.brk_after   = after_r;
    assign lnk.pc_trace_on = ctrl_r[`UBC_BIT_PC_TRACE];
endmodule

// >>> logic/ubc_if.sv
// Interface joining the break control logic to the core-side bus watcher.
`timescale 1ns/1ps
interface ubc_if;
    ubc_pkg::ubc_cycle_t cycle;
    logic                reg_wr;
    logic                reg_rd;
    logic [1:0]          reg_addr;
    logic [31:0]         reg_wdata;
    logic [31:0]         reg_rdata;
    logic                brk_req;
    logic                brk_after;
    logic                pc_trace_on;
    modport dev (input cycle, input reg_wr, input reg_rd, input reg_addr, input reg_wdata,
                 output reg_rdata, output brk_req, output brk_after, output pc_trace_on);
    modport core (output cycle, output reg_wr, output reg_rd, output reg_addr, output reg_wdata,
                  input reg_rdata, input brk_req, input brk_after, input pc_trace_on);
endinterface

// >>> logic/ubc_pkg.sv
// Types shared by both ends of the user break control block.
package ubc_pkg;
    typedef enum logic [1:0] {
        UBC_SEQ_IDLE  = 2'b00,
        UBC_SEQ_ARMED = 2'b01
    } ubc_seq_t;
    typedef struct packed {
        logic       valid;
        logic       is_dma;
        logic       is_fetch;
        logic [7:0] asid;
        logic       addr_a_hit;
        logic       addr_b_hit;
        logic       data_b_hit;
    } ubc_cycle_t;
endpackage
